// ---- design/fcmc_pkg.sv ----
/*
 package for the flash command and mode controller: pin widths, command codes,
 unlock cycle codes, status bit positions and timing counts.
 assumes a 100 MHz clock and an asynchronous parallel flash on the far side.
*/
package fcmc_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	// clock period in ns
	localparam int CLK_NS = 10;
	// write strobe low time, ns, and its least cycle count
	localparam int WE_LOW_NS     = 60;
	localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	// read access time, ns, and its least cycle count
	localparam int RD_ACC_NS     = 90;
	localparam int RD_ACC_CYC    = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
	// recovery after read/reset in block erase or after an error, us
	localparam int RECOVER_US    = 10;
	localparam int RECOVER_CYC   = (RECOVER_US * 1000 + CLK_NS - 1) / CLK_NS;
	// power-up ready delay, us
	localparam int POWERUP_US    = 50;
	localparam int POWERUP_CYC   = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 16;
	// unlock cycles (values arbitrary defaults, device specific)
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 18'h0_0555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 18'h0_02AA;
	localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
	localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
	// command bytes (values arbitrary defaults, device specific)
	localparam logic [DATA_W-1:0] CMD_RESET    = 8'hF0;
	localparam logic [DATA_W-1:0] CMD_PROGRAM  = 8'hA0;
	localparam logic [DATA_W-1:0] CMD_ERASE    = 8'h80;
	localparam logic [DATA_W-1:0] CMD_CHIP     = 8'h10;
	localparam logic [DATA_W-1:0] CMD_BLOCK    = 8'h30;
	localparam logic [DATA_W-1:0] CMD_SUSPEND  = 8'hB0;
	localparam logic [DATA_W-1:0] CMD_RESUME   = 8'h30;
	localparam logic [DATA_W-1:0] CMD_IDENT    = 8'h90;
	// status bit positions
	localparam int POLL_BIT   = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERROR_BIT  = 5;
	// user operation codes
	localparam logic [2:0] OP_READ    = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_CHIP    = 3'h2;
	localparam logic [2:0] OP_BLOCK   = 3'h3;
	localparam logic [2:0] OP_SUSPEND = 3'h4;
	localparam logic [2:0] OP_RESUME  = 3'h5;
	localparam logic [2:0] OP_IDENT   = 3'h6;
	localparam logic [2:0] OP_RESET   = 3'h7;
	// result codes
	localparam logic [1:0] RES_OK    = 2'h0;
	localparam logic [1:0] RES_FAIL  = 2'h1;
	localparam logic [1:0] RES_BUSY  = 2'h2;
	typedef enum logic [7:0] {
		ST_POWERUP = 8'b0000_0001,
		ST_IDLE    = 8'b0000_0010,
		ST_WRITE   = 8'b0000_0100,
		ST_READ    = 8'b0000_1000,
		ST_POLL    = 8'b0001_0000,
		ST_RECOVER = 8'b0010_0000,
		ST_GAP     = 8'b0100_0000,
		ST_DONE    = 8'b1000_0000
	} fcmc_state_t;
endpackage

// ---- design/fcmc_bus_cycle.sv ----
/*
 one flash bus cycle: a write pulse on the write strobe or a timed read.
 assumes the flash pins are sampled synchronously; data pin is three signals.
*/
`timescale 1ns/1ns
module fcmc_bus_cycle
	import fcmc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  start,
	input  wire logic                  is_write,
	input  wire logic [fcmc_pkg::ADDR_W-1:0] addr,
	input  wire logic [fcmc_pkg::DATA_W-1:0] wdata,
	output logic                       done,
	output logic [fcmc_pkg::DATA_W-1:0] rdata,
	output logic [fcmc_pkg::ADDR_W-1:0] flash_addr,
	output logic                       flash_ce_n,
	output logic                       flash_oe_n,
	output logic                       flash_we_n,
	input  wire logic [fcmc_pkg::DATA_W-1:0] flash_dq_in,
	output logic [fcmc_pkg::DATA_W-1:0] flash_dq_out,
	output logic                       flash_dq_oe
);
	logic [7:0]  cnt, next_cnt;
	logic        busy, next_busy, wr, next_wr, next_done;
	logic [DATA_W-1:0] next_rdata;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_dq;

	// cycle timing: hold strobe low for the required count, capture at the end
	// done is registered so the captured byte already stands when done is seen;
	// no start is taken in the done cycle, so the caller can step on first
	always_comb begin
		next_cnt   = cnt;
		next_busy  = busy;
		next_wr    = wr;
		next_rdata = rdata;
		next_addr  = flash_addr;
		next_dq    = flash_dq_out;
		next_done  = 1'b0;
		if (!busy && start && !done) begin
			next_busy = 1'b1;
			next_wr   = is_write;
			next_addr = addr;
			next_dq   = wdata;
			next_cnt  = is_write ? 8'(WE_LOW_CYC) : 8'(RD_ACC_CYC);
		end else if (busy) begin
			if (cnt == 8'h01) begin
				next_busy = 1'b0;
				next_done = 1'b1;
				if (!wr)
					next_rdata = flash_dq_in;
			end
			next_cnt = cnt - 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt          <= 8'h00;
			busy         <= 1'b0;
			done         <= 1'b0;
			wr           <= 1'b0;
			rdata        <= 8'h00;
			flash_addr   <= 18'h0_0000;
			flash_dq_out <= 8'h00;
		end else begin
			cnt          <= next_cnt;
			busy         <= next_busy;
			done         <= next_done;
			wr           <= next_wr;
			rdata        <= next_rdata;
			flash_addr   <= next_addr;
			flash_dq_out <= next_dq;
		end
	end

	// strobes follow the busy state
	assign flash_ce_n  = !busy;
	assign flash_we_n  = !(busy && wr);
	assign flash_oe_n  = !(busy && !wr);
	assign flash_dq_oe = busy && wr;
endmodule

// ---- design/fcmc_ctrl.sv ----
/*
 host-side controller for a parallel flash with command sequences and status polling.
 takes user orders (read, program, erase, suspend, identify, reset) and turns
 them into write sequences (unlock-guarded for program, erase and identify), reads and status polls.
 assumes the flash sits on the pins below and one order is given at a time.
*/
`timescale 1ns/1ns
module fcmc_ctrl
	import fcmc_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire logic [2:0]                  req_op,
	input  wire logic [fcmc_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [fcmc_pkg::DATA_W-1:0] req_data,
	output logic                             rsp_valid,
	output logic [1:0]                       rsp_result,
	output logic [fcmc_pkg::DATA_W-1:0]      rsp_data,
	output logic                             id_mode,
	output logic                             suspended,
	output logic [fcmc_pkg::ADDR_W-1:0]      flash_addr,
	output logic                             flash_ce_n,
	output logic                             flash_oe_n,
	output logic                             flash_we_n,
	output logic                             reset_input_low,
	input  wire logic [fcmc_pkg::DATA_W-1:0] flash_dq_in,
	output logic [fcmc_pkg::DATA_W-1:0]      flash_dq_out,
	output logic                             flash_dq_oe
);
	import fcmc_pkg::*;

	logic              rs1, rst_n;
	fcmc_state_t       state, next_state;
	logic [2:0]        op, next_op;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] data, next_data;
	logic [2:0]        step, next_step;
	logic [CNT_W-1:0]  wait_cnt, next_wait_cnt;
	logic [DATA_W-1:0] prev, next_prev;
	logic              have_prev, next_have_prev;
	logic              next_rsp_valid;
	logic [1:0]        next_rsp_result;
	logic [DATA_W-1:0] next_rsp_data;
	logic              next_id_mode, next_suspended, in_erase, next_in_erase;
	logic              cyc_start, cyc_write, cyc_done;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_wdata, cyc_rdata;

	// write count of each order, unlock cycles counted
	function automatic logic [2:0] seq_len(input logic [2:0] o);
		case (o)
			OP_PROGRAM: seq_len = 3'd4;
			OP_CHIP:    seq_len = 3'd6;
			OP_BLOCK:   seq_len = 3'd6;
			OP_IDENT:   seq_len = 3'd3;
			default:    seq_len = 3'd1;
		endcase
	endfunction

	// address and data of write number s of an order
	function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input logic [2:0] o,
			input logic [2:0] s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic u;
		u = (s == 3'd0) || (s == 3'd3);
		if (o == OP_SUSPEND)
			seq_word = {a, CMD_SUSPEND};
		else if (o == OP_RESUME)
			seq_word = {a, CMD_RESUME};
		else if (o == OP_RESET)
			seq_word = {UNLOCK_ADDR1, CMD_RESET};
		else if (s == 3'd2 && o == OP_PROGRAM)
			seq_word = {UNLOCK_ADDR1, CMD_PROGRAM};
		else if (s == 3'd3 && o == OP_PROGRAM)
			seq_word = {a, d};
		else if (s == 3'd2 && o == OP_IDENT)
			seq_word = {UNLOCK_ADDR1, CMD_IDENT};
		else if (s == 3'd2)
			seq_word = {UNLOCK_ADDR1, CMD_ERASE};
		else if (s == 3'd5 && o == OP_CHIP)
			seq_word = {UNLOCK_ADDR1, CMD_CHIP};
		else if (s == 3'd5)
			seq_word = {a, CMD_BLOCK};
		else if (u)
			seq_word = {UNLOCK_ADDR1, UNLOCK_DATA1};
		else
			seq_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs1   <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1   <= 1'b1;
			rst_n <= rs1;
		end
	end

	assign reset_input_low = 1'b1;
	assign req_ready = (state == ST_IDLE) || (state == ST_POLL && in_erase && cyc_done
		&& req_op == OP_SUSPEND);
	assign {cyc_addr, cyc_wdata} = seq_word(op, step, addr, data);

	fcmc_bus_cycle u_cycle (
		.clk          (clk),
		.rst_n        (rst_n),
		.start        (cyc_start),
		.is_write     (cyc_write),
		.addr         (state == ST_WRITE ? cyc_addr : addr),
		.wdata        (cyc_wdata),
		.done         (cyc_done),
		.rdata        (cyc_rdata),
		.flash_addr   (flash_addr),
		.flash_ce_n   (flash_ce_n),
		.flash_oe_n   (flash_oe_n),
		.flash_we_n   (flash_we_n),
		.flash_dq_in  (flash_dq_in),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe)
	);

	// order sequencer: writes, reads, status poll and recovery waits
	always_comb begin
		next_state      = state;
		next_op         = op;
		next_addr       = addr;
		next_data       = data;
		next_step       = step;
		next_wait_cnt   = wait_cnt;
		next_prev       = prev;
		next_have_prev  = have_prev;
		next_rsp_valid  = 1'b0;
		next_rsp_result = rsp_result;
		next_rsp_data   = rsp_data;
		next_id_mode    = id_mode;
		next_suspended  = suspended;
		next_in_erase   = in_erase;
		cyc_start       = 1'b0;
		cyc_write       = 1'b0;
		case (state)
			ST_POWERUP: begin
				if (wait_cnt == '0)
					next_state = ST_IDLE;
				else
					next_wait_cnt = wait_cnt - 1'b1;
			end
			ST_IDLE: begin
				if (req_valid) begin
					next_op   = req_op;
					next_addr = req_addr;
					next_data = req_data;
					next_step = 3'd0;
					next_state = (req_op == OP_READ) ? ST_READ : ST_WRITE;
				end
			end
			ST_WRITE: begin
				cyc_start = 1'b1;
				cyc_write = 1'b1;
				if (cyc_done) begin
					next_step = step + 3'd1;
					if (step + 3'd1 == seq_len(op)) begin
						next_state = ST_DONE;
						next_rsp_result = RES_OK;
						case (op)
							OP_PROGRAM, OP_CHIP, OP_BLOCK: begin
								next_state     = ST_POLL;
								next_have_prev = 1'b0;
								next_in_erase  = (op == OP_BLOCK);
							end
							OP_IDENT:   next_id_mode = 1'b1;
							OP_SUSPEND: next_suspended = in_erase;
							OP_RESUME: begin
								next_suspended = 1'b0;
								next_have_prev = 1'b0;
								next_state     = in_erase ? ST_POLL : ST_DONE;
							end
							default: begin
								next_id_mode   = 1'b0;
								next_suspended = 1'b0;
								if (in_erase) begin
									next_in_erase = 1'b0;
									next_wait_cnt = CNT_W'(RECOVER_CYC);
									next_state    = ST_RECOVER;
								end
							end
						endcase
					end
				end
			end
			ST_READ: begin
				cyc_start = 1'b1;
				if (cyc_done) begin
					next_rsp_data   = cyc_rdata;
					next_rsp_result = RES_OK;
					next_state      = ST_DONE;
				end
			end
			ST_POLL: begin
				cyc_start = 1'b1;
				if (cyc_done) begin
					next_prev      = cyc_rdata;
					next_have_prev = 1'b1;
					if (req_valid && req_ready) begin
						next_op    = OP_SUSPEND;
						next_addr  = req_addr;
						next_step  = 3'd0;
						next_state = ST_WRITE;
					end else if (have_prev && prev[TOGGLE_BIT] == cyc_rdata[TOGGLE_BIT]) begin
						next_in_erase   = 1'b0;
						next_rsp_data   = cyc_rdata;
						next_rsp_result = RES_OK;
						next_state      = ST_DONE;
					end else if (cyc_rdata[ERROR_BIT]) begin
						next_state = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				cyc_start = 1'b1;
				if (cyc_done) begin
					next_rsp_data = cyc_rdata;
					next_in_erase = 1'b0;
					if (prev[TOGGLE_BIT] == cyc_rdata[TOGGLE_BIT]) begin
						next_rsp_result = RES_OK;
						next_state      = ST_DONE;
					end else begin
						next_rsp_result = RES_FAIL;
						next_op         = OP_RESET;
						next_step       = 3'd0;
						next_state      = ST_RECOVER;
						next_wait_cnt   = CNT_W'(RECOVER_CYC);
					end
				end
			end
			ST_RECOVER: begin
				if (wait_cnt == '0)
					next_state = ST_DONE;
				else
					next_wait_cnt = wait_cnt - 1'b1;
			end
			default: begin
				next_rsp_valid = 1'b1;
				next_state     = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_POWERUP;
			op         <= OP_READ;
			addr       <= 18'h0_0000;
			data       <= 8'h00;
			step       <= 3'd0;
			wait_cnt   <= CNT_W'(POWERUP_CYC);
			prev       <= 8'h00;
			have_prev  <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_result <= 2'h0;
			rsp_data   <= 8'h00;
			id_mode    <= 1'b0;
			suspended  <= 1'b0;
			in_erase   <= 1'b0;
		end else begin
			state      <= next_state;
			op         <= next_op;
			addr       <= next_addr;
			data       <= next_data;
			step       <= next_step;
			wait_cnt   <= next_wait_cnt;
			prev       <= next_prev;
			have_prev  <= next_have_prev;
			rsp_valid  <= next_rsp_valid;
			rsp_result <= next_rsp_result;
			rsp_data   <= next_rsp_data;
			id_mode    <= next_id_mode;
			suspended  <= next_suspended;
			in_erase   <= next_in_erase;
		end
	end
endmodule

// ---- tb/fcmc_ctrl_asserts.sv ----
/*
 checker for the flash controller pins and order handshake.
 assumes it is bound to fcmc_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
module fcmc_ctrl_asserts
	import fcmc_pkg::*;
(
	input wire logic                        clk,
	input wire logic                        resetn,
	input wire logic                        req_valid,
	input wire logic                        req_ready,
	input wire logic [2:0]                  req_op,
	input wire logic                        rsp_valid,
	input wire logic [fcmc_pkg::ADDR_W-1:0] flash_addr,
	input wire logic                        flash_ce_n,
	input wire logic                        flash_oe_n,
	input wire logic                        flash_we_n,
	input wire logic                        reset_input_low,
	input wire logic [fcmc_pkg::DATA_W-1:0] flash_dq_out,
	input wire logic                        flash_dq_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic first;
	logic next_first;
	// marks that the next write pulse opens a command sequence
	always_comb begin
		next_first = first;
		if (req_valid && req_ready)
			next_first = !(req_op inside {OP_READ, OP_SUSPEND, OP_RESUME, OP_RESET});
		else if (!flash_we_n)
			next_first = 1'b0;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			first <= 1'b0;
		else
			first <= next_first;
	end
	sequence we_low;
		!flash_we_n[*6] ##1 flash_we_n;
	endsequence
	sequence rd_low;
		!flash_oe_n[*8] ##1 !flash_oe_n ##1 flash_oe_n;
	endsequence
	pin_high_a: assert property (reset_input_low)
		else $error("flash reset pin driven low");
	rsp_once_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer pulse longer than one cycle");
	taken_busy_a: assert property (req_valid && req_ready |=> !req_ready)
		else $error("new order offered while busy");
	no_fight_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
		else $error("data driven or written during a read");
	ce_follow_a: assert property (!(flash_oe_n && flash_we_n) |-> !flash_ce_n)
		else $error("strobe without chip enable");
	we_width_a: assert property ($fell(flash_we_n) |-> we_low)
		else $error("write pulse width wrong");
	rd_width_a: assert property ($fell(flash_oe_n) |-> rd_low)
		else $error("read pulse width wrong");
	wr_stable_a: assert property (!flash_we_n && $past(!flash_we_n)
		|-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("write address or data moved");
	unlock_first_a: assert property ($fell(flash_we_n) && first
		|-> flash_addr == UNLOCK_ADDR1 && flash_dq_out == UNLOCK_DATA1 && flash_dq_oe)
		else $error("sequence without unlock write");
endmodule
bind fcmc_ctrl fcmc_ctrl_asserts i_fcmc_ctrl_asserts (
	.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
	.req_op(req_op), .rsp_valid(rsp_valid), .flash_addr(flash_addr),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.reset_input_low(reset_input_low), .flash_dq_out(flash_dq_out),
	.flash_dq_oe(flash_dq_oe)
);

// ---- tb/fcmc_flash_model.sv ----
/*
 behavioural parallel flash: 16 byte array, command decoder, status reads.
 assumes writes latch on the write strobe rising edge; no clock.
*/
`timescale 1ns/1ns
module fcmc_flash_model
	import fcmc_pkg::*;
#(
	parameter int         BUSY_READS = 3,
	parameter logic [7:0] MAKER_CODE = 8'h3E, // arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'h6B, // arbitrary value
	parameter logic [3:0] PROT       = 4'b0010
)
(
	input  wire logic [fcmc_pkg::ADDR_W-1:0] addr,
	input  wire logic                        ce_n,
	input  wire logic                        oe_n,
	input  wire logic                        we_n,
	input  wire logic                        rst_low,
	input  wire logic [fcmc_pkg::DATA_W-1:0] wdata,
	input  wire logic                        fail_next,
	output logic [fcmc_pkg::DATA_W-1:0]      rdata
);
	logic [7:0] mem [16];
	logic [7:0] wd, rd, last;
	logic [3:0] a;
	logic id, tog, err, susp, wsel, rsel;
	int step, busy;
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 8'hC0 + 8'(i);
		{step, busy, id, tog, err, susp, wsel, rsel, last, wd} = '0;
	end
	// chip enable moves with the strobes, so it is looked at just after they fall
	always @(negedge we_n) #1 wsel = !ce_n;
	always @(negedge oe_n) #1 rsel = !ce_n;
	// command decoder: coded unlock writes open program, erase and identify; suspend, resume and reset are single writes
	always @(posedge we_n or negedge rst_low) begin
		if (!rst_low) begin
			step = 0;
			id = 1'b0;
			busy = 0;
			susp = 1'b0;
		end else if (wsel) begin
			a = addr[3:0];
			if (step == 0 && wdata == CMD_SUSPEND && busy > 0)
				susp = 1'b1;
			if (step == 0 && wdata == CMD_RESUME && susp)
				susp = 1'b0;
			if (step == 2 && wdata == CMD_IDENT)
				id = 1'b1;
			if (step == 0 && wdata == CMD_RESET) begin
				id = 1'b0;
				busy = 0;
			end
			case (step)
				// a suspend write leaves the array readable; a resume write brings back status reads while busy
				0: step = (addr == UNLOCK_ADDR1 && wdata == UNLOCK_DATA1) ? 1 : 0;
				1: step = (addr == UNLOCK_ADDR2 && wdata == UNLOCK_DATA2) ? 2 : 0;
				2: step = wdata == CMD_PROGRAM ? 3 : wdata == CMD_ERASE ? 4 : 0;
				4: step = (addr == UNLOCK_ADDR1 && wdata == UNLOCK_DATA1) ? 5 : 0;
				5: step = (addr == UNLOCK_ADDR2 && wdata == UNLOCK_DATA2) ? 6 : 0;
				default: begin
					// pulses and preprogramming are internal; host only polls
					wd = step == 3 ? wdata : 8'hFF;
					if (step == 3)
						mem[a] = mem[a] & wdata;
					for (int i = 0; i < 16; i++)
						if (wdata == CMD_CHIP || (wdata == CMD_BLOCK && i[3:2] == a[3:2]))
							mem[i] = step == 6 ? 8'hFF : mem[i];
					busy = BUSY_READS;
					err = fail_next;
					step = 0;
				end
			endcase
		end
	end
	// status while busy or failed, id data in id mode, else array; suspended shows array
	always_comb begin
		if (busy > 0 && !susp)
			rd = {~wd[7], tog, err, 5'h00};
		else if (id)
			rd = addr[1] ? {7'h00, PROT[addr[3:2]]} : addr[0] ? DEV_CODE : MAKER_CODE;
		else
			rd = mem[addr[3:0]];
		rdata = (!ce_n && !oe_n) ? rd : ~last;
	end
	// each status read flips the toggle bit; a failed operation stays busy until a reset write
	always @(posedge oe_n) begin
		last = rd;
		if (rsel && busy > 0 && !susp) begin
			tog = ~tog;
			busy = err ? busy : busy - 1;
		end
	end
endmodule

// ---- tb/test_flash_command_mode_control.sv ----
/*
 testbench for the flash controller with a flash model on its pins.
 assumes a 100 MHz clock and the package timing counts.
*/
`timescale 1ns/1ns
module test_flash_command_mode_control;
	import fcmc_pkg::*;
	localparam logic [7:0] MAKER = 8'h3E; // arbitrary value
	localparam logic [7:0] DEV   = 8'h6B; // arbitrary value
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic              req_valid = 1'b0;
	logic [2:0]        req_op = OP_READ;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_data = '0;
	logic              fail_next = 1'b0;
	logic              req_ready, rsp_valid, id_mode, suspended;
	logic              ce_n, oe_n, we_n, rp_n, dq_oe;
	logic [1:0]        rsp_result, res;
	logic [ADDR_W-1:0] fa;
	logic [DATA_W-1:0] rsp_data, rd, dq_in, dq_out, dev_dq;
	int                n_fail = 0;
	int                tests_run = 0;
	int                cyc;
	always #5 clk = ~clk;
	// wire level: controller drives on writes, flash otherwise
	assign dq_in = dq_oe ? dq_out : dev_dq;
	fcmc_ctrl i_fcmc_ctrl (
		.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_addr(req_addr), .req_data(req_data),
		.rsp_valid(rsp_valid), .rsp_result(rsp_result), .rsp_data(rsp_data),
		.id_mode(id_mode), .suspended(suspended), .flash_addr(fa),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.reset_input_low(rp_n), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe)
	);
	fcmc_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV)) i_fcmc_flash_model (
		.addr(fa), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_low(rp_n),
		.wdata(dq_out), .fail_next(fail_next), .rdata(dev_dq)
	);
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// present one order and hold it until the edge that takes it
	task automatic offer(input logic [2:0] op, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= ADDR_W'(a);
		req_data <= d;
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	// wait for the answer pulse; a missing answer counts as a mismatch
	task automatic answer();
		cyc = 0;
		while (rsp_valid !== 1'b1 && cyc < 30000) begin
			@(negedge clk);
			cyc++;
		end
		if (rsp_valid !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: no answer to order", $time);
		end
		res = rsp_result;
		rd = rsp_data;
	endtask
	// one order: offer it, then wait for its answer before the next
	task automatic issue(input logic [2:0] op, input logic [3:0] a, input logic [7:0] d);
		offer(op, a, d);
		answer();
	endtask
	task automatic t_read();
		issue(OP_READ, 3, 0);
		check(rd, 8'hC3);
	endtask
	task automatic t_program();
		issue(OP_PROGRAM, 2, 8'h5A);
		check(6'h00 + res, RES_OK);
		issue(OP_READ, 2, 0);
		check(rd, 8'h42);
	endtask
	task automatic t_ident();
		issue(OP_IDENT, 0, 0);
		check(7'h00 + id_mode, 8'h01);
		issue(OP_READ, 0, 0);
		check(rd, MAKER);
		issue(OP_READ, 1, 0);
		check(rd, DEV);
		issue(OP_READ, 6, 0);
		check(rd, 8'h01);
		issue(OP_READ, 2, 0);
		check(rd, 8'h00);
		issue(OP_RESET, 0, 0);
		check(7'h00 + id_mode, 8'h00);
		issue(OP_READ, 3, 0);
		check(rd, 8'hC3);
	endtask
	task automatic t_fail();
		fail_next <= 1'b1;
		issue(OP_PROGRAM, 5, 8'h00);
		fail_next <= 1'b0;
		check(6'h00 + res, RES_FAIL);
		check(7'h00 + (cyc >= RECOVER_CYC), 8'h01);
		issue(OP_RESET, 0, 0);
		issue(OP_READ, 4, 0);
		check(rd, 8'hC4);
	endtask
	// suspend with no erase running, then a block erase cut by a suspend
	task automatic t_erase();
		issue(OP_SUSPEND, 8, 0);
		check(7'h00 + suspended, 8'h00);
		offer(OP_BLOCK, 8, 0);
		offer(OP_SUSPEND, 8, 0);
		answer();
		check(6'h00 + res, RES_OK);
		check(7'h00 + suspended, 8'h01);
		issue(OP_READ, 4, 0);
		check(rd, 8'hC4);
		issue(OP_RESUME, 8, 0);
		check(6'h00 + res, RES_OK);
		check(7'h00 + suspended, 8'h00);
		issue(OP_READ, 9, 0);
		check(rd, 8'hFF);
		issue(OP_READ, 1, 0);
		check(rd, 8'hC1);
		issue(OP_CHIP, 0, 0);
		check(6'h00 + res, RES_OK);
		issue(OP_READ, 2, 0);
		check(rd, 8'hFF);
	endtask
	task automatic finish_test();
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_read();
		t_program();
		t_ident();
		t_fail();
		t_erase();
		finish_test();
	end
	// watchdog: power-up wait, one recovery and short orders fit well inside
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
endmodule
